// File: design/dss_drive_speed.sv
// Behaviour
// - inhibited state shows status bit 6 set and state bits 000.
// - ready shows bit 6 clear with 001; operation shows bit 6 clear with 111.
// - switched-on, ramp stop and quick stop show bit 6 clear with 011.
// - control bits 1, 2, 10 are mirrored into status bits 4, 5, 9.
// - status bits 3 and 7 come from operator fault and warning inputs.
// - status bits 8 and 10 come from the lagged actual speed model.
// - without an expansion attached, status bits 11 to 15 read zero.
// - without expansion, control bits 11 to 15 ignored; otherwise passed on.
// - control bits 0-3 steer switching; jog bits 8 and 9 are unused.
// - control bit 7 is the fault acknowledge request.
// - control bit 6 loads the speed setpoint, limited to nominal and to lim, as ramp target.
// - in operation, control bit 5 lets the ramp move linearly, else it holds; other states always run it.
// - ramp output is passed on as setpoint only with control bit 4.
// - setpoint is connected only in operation; elsewhere it is zero.
// - status bit 8 set while actual speed is within window around setpoint output.
// - status bit 10 set when actual speed reaches the compare level.
// - on error the ramp winds down at the emergency slope; the setpoint output is zero.
// - setpoint is output as percent of nominal and as process value.
// - raw setpoint and actual words span 0 to 16384 at nominal speed.
// - percentage output spans 0 at standstill to 100 at nominal.
`timescale 1ns/1ps
module dss_drive_speed import dss_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [W-1:0] reg_rdata,
  input wire logic [W-1:0] process_actual_speed,
  input wire logic fault_switch,
  input wire logic warning_switch,
  input wire logic expansion_present,
  input wire logic [XW-1:0] expansion_status,
  output logic [W-1:0] status_word_one,
  output logic [W-1:0] raw_speed_actual,
  output logic [W-1:0] ramp_setpoint,
  output logic [PW-1:0] setpoint_percent,
  output logic [W-1:0] process_setpoint_speed,
  output logic [XW-1:0] expansion_connector_ctrl
);

  typedef struct packed {
    dss_state_e state;
    logic [W-1:0] ctrl;
    logic [W-1:0] setp;
    logic [W-1:0] slope;
    logic [W-1:0] eslope;
    logic [W-1:0] tol;
    logic [W-1:0] cmp;
    logic [W-1:0] nom;
    logic [W-1:0] lim;
    logic [2:0] flt_sync;
    logic [2:0] wrn_sync;
    logic fault_on;
    logic warn_on;
    logic fault_latched;
    logic ack_prev;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [W-1:0] actual;
    logic [W-1:0] status;
    logic [W-1:0] sp_out;
    logic [PW-1:0] pct;
    logic [W-1:0] proc_sp;
    logic [XW-1:0] exp_ctrl;
    logic [W-1:0] rdata;
  } dss_core_s;

  dss_core_s cur;
  dss_core_s next_cur;
  dss_ramp_if rfi ();

  logic error;
  logic ack_rise;
  logic [W-1:0] sp_clamped;
  logic [W:0] lag_diff;
  logic [W:0] lag_step;
  logic [W-1:0] tol_dist;
  logic [W+PW-1:0] pct_prod;
  logic [2*W-1:0] proc_prod;
  logic [2:0] sm_code;

  dss_ramp_function_generator u_ramp (
    .sys_clk(sys_clk),
    .rst(rst),
    .rf(rfi.gen)
  );

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_cur = cur;

    // operator switches are asynchronous; a change counts once stages 2 and 3 agree
    next_cur.flt_sync = {cur.flt_sync[1:0], fault_switch};
    next_cur.wrn_sync = {cur.wrn_sync[1:0], warning_switch};
    if (cur.flt_sync[2] == cur.flt_sync[1]) begin
      next_cur.fault_on = cur.flt_sync[2];
    end
    if (cur.wrn_sync[2] == cur.wrn_sync[1]) begin
      next_cur.warn_on = cur.wrn_sync[2];
    end

    // step divider for the ramp and the lag model
    next_cur.tick = 1'b0;
    next_cur.tick_cnt = cur.tick_cnt + 1'b1;
    if (cur.tick_cnt == TICK_LAST) begin
      next_cur.tick_cnt = '0;
      next_cur.tick = 1'b1;
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        RA_CTRL: next_cur.ctrl = reg_wdata;
        RA_SETP: next_cur.setp = reg_wdata;
        RA_SLOPE: next_cur.slope = reg_wdata;
        RA_ESLOPE: next_cur.eslope = reg_wdata;
        RA_TOL: next_cur.tol = reg_wdata;
        RA_CMP: next_cur.cmp = reg_wdata;
        RA_NOM: next_cur.nom = reg_wdata;
        RA_LIM: next_cur.lim = reg_wdata;
        default: ;
      endcase
    end

    // fault latch: a new fault beats an acknowledge in the same cycle
    ack_rise = cur.ctrl[CB_ACK] & ~cur.ack_prev;
    next_cur.ack_prev = cur.ctrl[CB_ACK];
    if (cur.fault_on) begin
      next_cur.fault_latched = 1'b1;
    end else if (ack_rise) begin
      next_cur.fault_latched = 1'b0;
    end
    error = cur.fault_latched;

    // switching state machine; jog bits 8 and 9 deliberately unused
    if (!cur.ctrl[CB_NO_COAST] || error) begin
      next_cur.state = ST_INHIBIT;
    end else begin
      unique case (cur.state)
        ST_INHIBIT: begin
          if (!cur.ctrl[CB_ON] && cur.ctrl[CB_NO_QUICK]) next_cur.state = ST_READY;
        end
        ST_READY: begin
          if (!cur.ctrl[CB_NO_QUICK]) next_cur.state = ST_INHIBIT;
          else if (cur.ctrl[CB_ON]) next_cur.state = ST_SWON;
        end
        ST_SWON: begin
          if (!cur.ctrl[CB_NO_QUICK]) next_cur.state = ST_INHIBIT;
          else if (!cur.ctrl[CB_ON]) next_cur.state = ST_READY;
          else if (cur.ctrl[CB_EN_OP]) next_cur.state = ST_OPER;
        end
        ST_OPER: begin
          if (!cur.ctrl[CB_NO_QUICK]) next_cur.state = ST_QSTOP;
          else if (!cur.ctrl[CB_ON]) next_cur.state = ST_RAMPSTOP;
          else if (!cur.ctrl[CB_EN_OP]) next_cur.state = ST_SWON;
        end
        ST_RAMPSTOP: begin
          if (!cur.ctrl[CB_NO_QUICK]) next_cur.state = ST_QSTOP;
          else if (rfi.out == '0) next_cur.state = ST_READY;
        end
        ST_QSTOP: begin
          if (rfi.out == '0) next_cur.state = ST_INHIBIT;
        end
      endcase
    end

    // ramp control: only operation feeds a real target, all else winds down to zero
    sp_clamped = (cur.setp > RAW_NOMINAL) ? RAW_NOMINAL : cur.setp;
    if (sp_clamped > cur.lim) begin
      sp_clamped = cur.lim;
    end
    rfi.target = '0;
    if (cur.state == ST_OPER && !error && cur.ctrl[CB_EN_SP]) begin
      rfi.target = sp_clamped;
    end
    rfi.run = (cur.state != ST_OPER) || error || cur.ctrl[CB_UNFREEZE];
    rfi.slope = cur.slope;
    if (error || (cur.state != ST_OPER && cur.state != ST_RAMPSTOP)) begin
      rfi.slope = cur.eslope;
    end
    rfi.step = cur.tick;

    // setpoint connection
    next_cur.sp_out = '0;
    if (cur.state == ST_OPER && cur.ctrl[CB_EN_RAMP]) begin
      next_cur.sp_out = rfi.out;
    end
    pct_prod = cur.sp_out * PCT_FULL;
    next_cur.pct = pct_prod[RAW_SHIFT +: PW];
    proc_prod = cur.sp_out * cur.nom;
    next_cur.proc_sp = proc_prod[RAW_SHIFT +: W];

    // first-order lag of the actual speed; a small upward remainder closes in one step
    lag_diff = {1'b0, process_actual_speed} - {1'b0, cur.actual};
    lag_step = $signed(lag_diff) >>> PT1_SHIFT;
    if (lag_step == '0) begin
      lag_step = lag_diff;
    end
    if (cur.tick) begin
      next_cur.actual = cur.actual + lag_step[W-1:0];
    end

    // status word
    unique case (cur.state)
      ST_INHIBIT: sm_code = SM_INHIBIT;
      ST_READY: sm_code = SM_READY;
      ST_OPER: sm_code = SM_OPER;
      default: sm_code = SM_SWON;
    endcase
    tol_dist = (cur.actual >= cur.sp_out) ? cur.actual - cur.sp_out : cur.sp_out - cur.actual;
    next_cur.status = '0;
    next_cur.status[2:0] = sm_code;
    next_cur.status[SB_INHIBIT] = (cur.state == ST_INHIBIT);
    next_cur.status[SB_FAULT] = cur.fault_on;
    next_cur.status[SB_WARN] = cur.warn_on;
    next_cur.status[SB_NO_COAST] = cur.ctrl[CB_NO_COAST];
    next_cur.status[SB_NO_QUICK] = cur.ctrl[CB_NO_QUICK];
    next_cur.status[SB_PLC] = cur.ctrl[CB_PLC];
    // the window is tol wide in all, so half of it lies on each side of the setpoint
    next_cur.status[SB_TOL] = (tol_dist <= {1'b0, cur.tol[W-1:1]});
    next_cur.status[SB_REACHED] = (cur.actual >= cur.cmp);
    if (expansion_present) begin
      next_cur.status[W-1:XB_LO] = expansion_status;
    end

    // expansion connector sees device-specific control bits only when attached
    next_cur.exp_ctrl = expansion_present ? cur.ctrl[W-1:XB_LO] : '0;

    // read data live for the one cycle after the strobe
    next_cur.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        RA_CTRL: next_cur.rdata = cur.ctrl;
        RA_SETP: next_cur.rdata = cur.setp;
        RA_STATUS: next_cur.rdata = cur.status;
        RA_ACTUAL: next_cur.rdata = cur.actual;
        RA_SLOPE: next_cur.rdata = cur.slope;
        RA_ESLOPE: next_cur.rdata = cur.eslope;
        RA_TOL: next_cur.rdata = cur.tol;
        RA_CMP: next_cur.rdata = cur.cmp;
        RA_NOM: next_cur.rdata = cur.nom;
        RA_LIM: next_cur.rdata = cur.lim;
        RA_SPOUT: next_cur.rdata = cur.sp_out;
        RA_PCT: next_cur.rdata = {{(W-PW){1'b0}}, cur.pct};
        RA_PROC: next_cur.rdata = cur.proc_sp;
        default: next_cur.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur <= '0;
      cur.state <= ST_INHIBIT;
      cur.status <= RST_STATUS;
      cur.slope <= RST_SLOPE;
      cur.eslope <= RST_ESLOPE;
      cur.tol <= RST_TOL;
      cur.cmp <= RST_CMP;
      cur.nom <= RST_NOM;
      cur.lim <= RST_LIM;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign status_word_one = cur.status;
  assign raw_speed_actual = cur.actual;
  assign ramp_setpoint = cur.sp_out;
  assign setpoint_percent = cur.pct;
  assign process_setpoint_speed = cur.proc_sp;
  assign expansion_connector_ctrl = cur.exp_ctrl;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_inhibit_code: assert property (
    $past(cur.state) == ST_INHIBIT |-> status_word_one[SB_INHIBIT]
      && status_word_one[2:0] == SM_INHIBIT)
    else $error("inhibited status code wrong");

  a_ready_oper_code: assert property (
    ($past(cur.state) == ST_READY |-> !status_word_one[SB_INHIBIT]
      && status_word_one[2:0] == SM_READY)
    and ($past(cur.state) == ST_OPER |-> !status_word_one[SB_INHIBIT]
      && status_word_one[2:0] == SM_OPER))
    else $error("ready or operation status code wrong");

  a_stop_code: assert property (
    $past(cur.state) inside {ST_SWON, ST_RAMPSTOP, ST_QSTOP} |->
      !status_word_one[SB_INHIBIT] && status_word_one[2:0] == SM_SWON)
    else $error("switched-on or stop status code wrong");

  a_mirror_bits: assert property (
    reg_wr && reg_addr == RA_CTRL ##2 1'b1 |->
      status_word_one[SB_NO_COAST] == $past(reg_wdata[CB_NO_COAST], 2)
      && status_word_one[SB_PLC] == $past(reg_wdata[CB_PLC], 2))
    else $error("mirrored control bits wrong");

  a_exp_status_zero: assert property (
    !$past(expansion_present) |-> status_word_one[W-1:XB_LO] == '0)
    else $error("device-specific status bits not zero");

  a_exp_ctrl_gate: assert property (
    !expansion_present |=> expansion_connector_ctrl == '0)
    else $error("control bits leaked to expansion");

  a_sp_state_gate: assert property (
    (cur.state != ST_OPER || !cur.ctrl[CB_EN_RAMP]) |=> ramp_setpoint == '0)
    else $error("setpoint connected outside operation");

  a_speed_reached: assert property (
    status_word_one[SB_REACHED] == ($past(cur.actual) >= $past(cur.cmp)))
    else $error("speed reached flag wrong");

  a_coast_inhibit: assert property (
    !cur.ctrl[CB_NO_COAST] |=> cur.state == ST_INHIBIT)
    else $error("coast stop did not inhibit");

  a_fault_sticky: assert property (
    cur.fault_on |=> cur.fault_latched && status_word_one[SB_FAULT])
    else $error("fault latch lost");

endmodule : dss_drive_speed

// File: design/dss_pkg.sv
package dss_pkg;

  // ----------------------------------------
  // widths and scaling
  // ----------------------------------------
  localparam int W = 16;
  localparam int AW = 4;
  localparam int XW = 5;
  localparam int PW = 7;
  localparam int RAW_SHIFT = 14;
  localparam logic [W-1:0] RAW_NOMINAL = 16'h4000;
  localparam logic [PW-1:0] PCT_FULL = 7'h64;
  localparam int PT1_SHIFT = 3;

  // ----------------------------------------
  // timing: ramp and lag models step once per tick
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAMP_TICK_NS = 1000;
  localparam int TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 6;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ----------------------------------------
  // control word bit positions
  // ----------------------------------------
  localparam int CB_ON = 0;
  localparam int CB_NO_COAST = 1;
  localparam int CB_NO_QUICK = 2;
  localparam int CB_EN_OP = 3;
  localparam int CB_EN_RAMP = 4;
  localparam int CB_UNFREEZE = 5;
  localparam int CB_EN_SP = 6;
  localparam int CB_ACK = 7;
  localparam int CB_PLC = 10;
  localparam int XB_LO = 11;

  // ----------------------------------------
  // status word bit positions and state codes
  // ----------------------------------------
  localparam int SB_FAULT = 3;
  localparam int SB_NO_COAST = 4;
  localparam int SB_NO_QUICK = 5;
  localparam int SB_INHIBIT = 6;
  localparam int SB_WARN = 7;
  localparam int SB_TOL = 8;
  localparam int SB_PLC = 9;
  localparam int SB_REACHED = 10;
  localparam logic [2:0] SM_INHIBIT = 3'h0;
  localparam logic [2:0] SM_READY = 3'h1;
  localparam logic [2:0] SM_SWON = 3'h3;
  localparam logic [2:0] SM_OPER = 3'h7;

  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [AW-1:0] RA_CTRL = 4'h0;
  localparam logic [AW-1:0] RA_SETP = 4'h1;
  localparam logic [AW-1:0] RA_STATUS = 4'h2;
  localparam logic [AW-1:0] RA_ACTUAL = 4'h3;
  localparam logic [AW-1:0] RA_SLOPE = 4'h4;
  localparam logic [AW-1:0] RA_ESLOPE = 4'h5;
  localparam logic [AW-1:0] RA_TOL = 4'h6;
  localparam logic [AW-1:0] RA_CMP = 4'h7;
  localparam logic [AW-1:0] RA_NOM = 4'h8;
  localparam logic [AW-1:0] RA_LIM = 4'h9;
  localparam logic [AW-1:0] RA_SPOUT = 4'ha;
  localparam logic [AW-1:0] RA_PCT = 4'hb;
  localparam logic [AW-1:0] RA_PROC = 4'hc;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [W-1:0] RST_STATUS = 16'h0040;
  localparam logic [W-1:0] RST_SLOPE = 16'h0010;
  localparam logic [W-1:0] RST_ESLOPE = 16'h0100;
  localparam logic [W-1:0] RST_TOL = 16'h0100;
  localparam logic [W-1:0] RST_CMP = 16'h4000;
  localparam logic [W-1:0] RST_NOM = 16'h05dc;
  localparam logic [W-1:0] RST_LIM = 16'h4000;

  typedef enum logic [2:0] {
    ST_INHIBIT, ST_READY, ST_SWON, ST_OPER, ST_RAMPSTOP, ST_QSTOP
  } dss_state_e;

endpackage : dss_pkg

// File: design/dss_ramp_if.sv
`timescale 1ns/1ps
interface dss_ramp_if import dss_pkg::*; ();
  logic [W-1:0] target;
  logic [W-1:0] slope;
  logic run;
  logic step;
  logic [W-1:0] out;
  modport ctl (output target, output slope, output run, output step, input out);
  modport gen (input target, input slope, input run, input step, output out);
endinterface : dss_ramp_if

// File: design/dss_ramp_function_generator.sv
`timescale 1ns/1ps
module dss_ramp_function_generator import dss_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  dss_ramp_if.gen rf
);

  typedef struct packed {
    logic [W-1:0] out;
  } dss_ramp_s;

  dss_ramp_s cur;
  dss_ramp_s next_cur;
  logic [W:0] up;
  logic [W:0] dn;

  // ----------------------------------------
  // linear ramp, clipped so it never overshoots the target
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    up = {1'b0, cur.out} + {1'b0, rf.slope};
    dn = {1'b0, cur.out} - {1'b0, rf.slope};
    if (rf.run && rf.step) begin
      if (cur.out < rf.target) begin
        next_cur.out = (up[W] || up[W-1:0] > rf.target) ? rf.target : up[W-1:0];
      end else if (cur.out > rf.target) begin
        next_cur.out = (dn[W] || dn[W-1:0] < rf.target) ? rf.target : dn[W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rf.out = cur.out;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ramp_frozen_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !rf.run ##1 !rf.run |-> rf.out == $past(rf.out))
    else $error("ramp output moved while frozen");

  a_ramp_step_size: assert property (@(posedge sys_clk) disable iff (rst)
    (rf.run && rf.step && rf.out < rf.target && rf.slope != '0) |=>
      (rf.out > $past(rf.out)) && (rf.out - $past(rf.out) <= $past(rf.slope))
      && (rf.out <= $past(rf.target)))
    else $error("ramp step wrong size");

endmodule : dss_ramp_function_generator

// File: test/dss_plc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller side: cyclic words over the register port
// ----------------------------------------
module dss_plc_model import dss_pkg::*; (
  input wire logic sys_clk,
  output logic [AW-1:0] reg_addr,
  output logic [W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [W-1:0] reg_rdata,
  output logic [W-1:0] process_actual_speed
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    process_actual_speed = '0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // idle bus shows inverted values so a stale sample is caught
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [W-1:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // data stand only in the cycle after the strobe edge
    #1;
    d = reg_rdata;
  endtask : rd

  // bit 0 on, 1 no coast stop, 2 no quick stop, 3 enable operation
  task automatic ctrl(input logic [W-1:0] cw);
    wr(RA_CTRL, cw);
  endtask : ctrl

  // acknowledge is a rising edge on bit 7, the rest kept
  task automatic ack(input logic [W-1:0] cw);
    ctrl(cw & ~16'h0080);
    ctrl(cw | 16'h0080);
  endtask : ack

  task automatic speed(input logic [W-1:0] v);
    @(posedge sys_clk);
    process_actual_speed <= (v > RAW_NOMINAL) ? RAW_NOMINAL : v;
  endtask : speed
endmodule : dss_plc_model

// File: test/dss_drive_speed_bench.sv
`timescale 1ns/1ps
module dss_drive_speed_bench import dss_pkg::*;;
  localparam int LIMIT = 40000;
  logic sys_clk;
  logic rst;
  logic [AW-1:0] reg_addr;
  logic [W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [W-1:0] reg_rdata;
  logic [W-1:0] act;
  logic fault_switch;
  logic warning_switch;
  logic expansion_present;
  logic [XW-1:0] expansion_status;
  logic [W-1:0] sw;
  logic [W-1:0] raw_speed_actual;
  logic [W-1:0] sp;
  logic [PW-1:0] pct;
  logic [W-1:0] proc_sp;
  logic [XW-1:0] xc;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [W-1:0] v;
  logic [W-1:0] v1;
  logic [AW-1:0] ra[6] = '{RA_SLOPE, RA_ESLOPE, RA_TOL, RA_CMP, RA_NOM, RA_LIM};
  logic [W-1:0] rv[6] = '{RST_SLOPE, RST_ESLOPE, RST_TOL, RST_CMP, RST_NOM, RST_LIM};

  always #10 sys_clk = ~sys_clk;

  dss_plc_model plc (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .process_actual_speed(act));

  dss_drive_speed DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .process_actual_speed(act), .fault_switch(fault_switch),
    .warning_switch(warning_switch), .expansion_present(expansion_present),
    .expansion_status(expansion_status), .status_word_one(sw),
    .raw_speed_actual(raw_speed_actual), .ramp_setpoint(sp), .setpoint_percent(pct),
    .process_setpoint_speed(proc_sp), .expansion_connector_ctrl(xc));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // hang guard: well above the summed waits of all tests
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  task automatic t_reset();
    #1;
    chk(sw, RST_STATUS);
    chk(sp, 16'h0000);
    w(1);
    chk(sw, RST_STATUS | 16'h0100);
    for (int i = 0; i < 6; i++) begin
      plc.rd(ra[i], v);
      chk(v, rv[i]);
    end
    $display("t_reset done");
  endtask : t_reset

  task automatic t_bus();
    plc.wr(RA_STATUS, 16'hffff);
    plc.rd(RA_STATUS, v);
    chk(v, RST_STATUS | 16'h0100);
    plc.rd(4'hf, v);
    chk(v, 16'h0000);
    plc.wr(RA_SLOPE, 16'h0400);
    plc.rd(RA_SLOPE, v);
    chk(v, 16'h0400);
    w(1);
    chk(reg_rdata, 16'h0000);
    $display("t_bus done");
  endtask : t_bus

  task automatic t_switch_on();
    plc.ctrl(16'h0006);
    w(3);
    chk(sw & 16'h0077, 16'h0031);
    plc.ctrl(16'h0407);
    w(3);
    chk(sw & 16'h0277, 16'h0233);
    plc.ctrl(16'h000f);
    w(3);
    plc.rd(RA_STATUS, v);
    chk(v & 16'h0277, 16'h0037);
    $display("t_switch_on done");
  endtask : t_switch_on

  task automatic t_ramp();
    plc.wr(RA_SETP, 16'h2000);
    plc.ctrl(16'h007f);
    w(120);
    plc.ctrl(16'h005f);
    w(5);
    v1 = sp;
    w(150);
    chk(sp, v1);
    chk(v1 & 16'h03ff, 16'h0000);
    chk(W'(v1 == 16'h0000 || v1 == 16'h2000), 16'h0000);
    plc.ctrl(16'h007f);
    w(500);
    chk(sp, 16'h2000);
    chk({9'h0, pct}, 16'h0032);
    chk(proc_sp, 16'h02ee);
    plc.wr(RA_SETP, 16'h5000);
    w(500);
    chk(sp, RAW_NOMINAL);
    chk({9'h0, pct}, {9'h0, PCT_FULL});
    plc.ctrl(16'h006f);
    w(3);
    chk(sp, 16'h0000);
    plc.ctrl(16'h007f);
    w(3);
    chk(sp, RAW_NOMINAL);
    plc.ctrl(16'h003f);
    w(900);
    chk(sp, 16'h0000);
    plc.wr(RA_SETP, 16'h1000);
    plc.ctrl(16'h007f);
    w(400);
    chk(sp, 16'h1000);
    $display("t_ramp done");
  endtask : t_ramp

  task automatic t_window();
    plc.wr(RA_CMP, 16'h0800);
    plc.speed(16'h1000);
    w(3000);
    chk(raw_speed_actual, 16'h1000);
    chk(sw & 16'h0500, 16'h0500);
    plc.speed(16'h0800);
    w(3000);
    chk(sw & 16'h0500, 16'h0400);
    plc.speed(16'h07ff);
    w(3000);
    chk(sw & 16'h0500, 16'h0000);
    // window 0x100 wide around a setpoint of 0x1000
    plc.speed(16'h107f);
    w(3000);
    chk(sw & 16'h0100, 16'h0100);
    plc.speed(16'h1081);
    w(200);
    chk(sw & 16'h0100, 16'h0000);
    $display("t_window done");
  endtask : t_window

  task automatic t_expansion();
    plc.ctrl(16'hfb7f);
    w(3);
    chk(sw & 16'hf847, 16'h0007);
    chk({11'h0, xc}, 16'h0000);
    @(posedge sys_clk);
    expansion_present <= 1'b1;
    expansion_status <= 5'h15;
    w(3);
    chk(sw & 16'hf800, 16'ha800);
    chk({11'h0, xc}, 16'h001f);
    @(posedge sys_clk);
    expansion_status <= 5'h0a;
    w(2);
    chk(sw & 16'hf800, 16'h5000);
    @(posedge sys_clk);
    expansion_present <= 1'b0;
    plc.ctrl(16'h007f);
    $display("t_expansion done");
  endtask : t_expansion

  task automatic t_stops();
    plc.ctrl(16'h007e);
    w(3);
    chk(sw & 16'h0047, 16'h0003);
    chk(sp, 16'h0000);
    w(600);
    chk(sw & 16'h0047, 16'h0001);
    plc.ctrl(16'h007f);
    w(400);
    chk(sw & 16'h0047, 16'h0007);
    plc.ctrl(16'h007b);
    w(3);
    chk(sw & 16'h0047, 16'h0003);
    // normal slope would have finished by now
    w(500);
    chk(sw & 16'h0047, 16'h0003);
    w(600);
    chk(sw & 16'h0047, 16'h0040);
    plc.ctrl(16'h0006);
    plc.ctrl(16'h007f);
    w(10);
    plc.ctrl(16'h007d);
    w(3);
    chk(sw & 16'h0047, 16'h0040);
    $display("t_stops done");
  endtask : t_stops

  task automatic t_fault();
    plc.ctrl(16'h0006);
    w(3);
    @(posedge sys_clk);
    fault_switch <= 1'b1;
    w(10);
    chk(sw & 16'h004f, 16'h0048);
    @(posedge sys_clk);
    fault_switch <= 1'b0;
    w(10);
    plc.ctrl(16'h0006);
    w(3);
    chk(sw & 16'h0047, 16'h0040);
    plc.ack(16'h0006);
    w(3);
    chk(sw & 16'h004f, 16'h0001);
    @(posedge sys_clk);
    warning_switch <= 1'b1;
    w(10);
    chk(sw & 16'h00cf, 16'h0081);
    @(posedge sys_clk);
    warning_switch <= 1'b0;
    w(10);
    chk(sw & 16'h00cf, 16'h0001);
    $display("t_fault done");
  endtask : t_fault

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    fault_switch = 1'b0;
    warning_switch = 1'b0;
    expansion_present = 1'b0;
    expansion_status = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_bus();
    t_switch_on();
    t_ramp();
    t_window();
    t_expansion();
    t_stops();
    t_fault();
    wrap_up();
  end
endmodule : dss_drive_speed_bench
